// ===== rtl/smw_pkg.sv
// Shared constants and types for the mode sequencer and watchdog
package smw_pkg;
   localparam int CLK_HZ = 25000000;
   localparam int RESET_STAY_US = 1000;
   localparam int VDD_LOW_TIMEOUT_MS = 150;
   localparam int WD_DEFAULT_MS = 150;
   localparam int NREQ_TIMEOUT_MS = 150;
   localparam int RESET_STAY_CYC = RESET_STAY_US * (CLK_HZ / 1000000);
   localparam int VDD_LOW_CYC = VDD_LOW_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int WD_DEFAULT_CYC = WD_DEFAULT_MS * (CLK_HZ / 1000);
   localparam int NREQ_CYC = NREQ_TIMEOUT_MS * (CLK_HZ / 1000);
   localparam int CNT_W = 32;
   localparam int SYNC_W = 13;
   localparam logic [1:0] MODE_SLEEP = 2'h0;
   localparam logic [1:0] MODE_STOP = 2'h1;
   localparam logic [1:0] MODE_NORMAL_CLR = 2'h2;
   localparam logic [1:0] MODE_NORMAL = 2'h3;
   localparam logic [1:0] LOW_POWER_SEL = 2'h3;
   localparam logic [2:0] SWITCHES_OFF = 3'h0;

   typedef enum {
      SM_POWERUP,
      SM_RESET,
      SM_NORMAL_REQ,
      SM_NORMAL,
      SM_STOP,
      SM_SLEEP
   } smw_state_type;

   // Command byte as written by the host
   typedef struct packed {
      logic [1:0] linSlew;
      logic linPullup;
      logic [2:0] switchEnable;
      logic [1:0] modeCtrl;
   } smw_cmd_type;

   // Analog condition inputs
   typedef struct packed {
      logic vddGood;
      logic regTempWarn;
      logic switchOverTemp;
      logic supplyOverVolt;
      logic supplyUnderVolt;
   } smw_cond_type;
endpackage

// ===== rtl/smw_sync.sv
// Two flip-flop synchroniser for a level
`timescale 1ns/1ps
module smw_sync #(
   parameter int W = 1
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstSync_n,
   // Data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);
   logic [W-1:0] meta;

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         meta <= '0;
         q <= '0;
      end else begin
         meta <= d;
         q <= meta;
      end
   end
endmodule

// ===== rtl/smw_timer.sv
// Loadable down counter that flags expiry
`timescale 1ns/1ps
module smw_timer #(
   parameter int W = 32
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rstSync_n,
   // Control
   input wire logic load,
   input wire logic [W-1:0] loadValue,
   input wire logic run,
   // Status
   output logic [W-1:0] count,
   output logic expired
);
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         count <= '0;
      end else if (load) begin
         count <= loadValue;
      end else if (run && count != '0) begin
         count <= count - W'(1);
      end
   end

   assign expired = (count == '0);
endmodule

// ===== rtl/smw_mode_ctrl.sv
// Mode sequencer, window watchdog and fault interrupt logic
`timescale 1ns/1ps
// Operation
// R1: Pulse interrupt low on regulator warning, switch shutdown, over- or undervoltage.
// R2: After an interrupt the next status read has bit 7 set plus source.
// R3: Wake-up from Stop by level inputs or bus drives interrupt low.
// R4: Receive output low while bus dominant, high while recessive.
// R5: Bus dominant while transmit input low, recessive while high.
// R6: Host clears watchdog by mode bits, only inside the open window.
// R7: Clear in closed window or no clear in time resets device.
// R8: First clear in Normal Request accepted anytime within 150 ms, no window.
// R9: Config pin open gives default period; grounded disables the watchdog.
// R10: Resistor period 0.991 times kilohms plus 0.648 ms, given as parameter.
// R11: Regulator warning sets its flag and interrupt; flag follows the condition.
// R12: Regulator warning detection disabled in Sleep and Stop.
// R13: Switch overtemperature turns all switches off, sets flag, raises interrupt.
// R14: Switch thermal flag follows condition; detection off in Sleep and Stop.
// R15: Power-up enters Reset for 1 ms; supply low 150 ms goes Sleep.
// R16: Reset passes after 1 ms into Normal Request with bus active.
// R17: Normal Request drops reset on undervoltage or first-clear timeout.
// R18: Normal drops reset on undervoltage or watchdog failure, else high.
// R19: Sleep or Stop pattern needed in two consecutive commands. Code checks the full pattern on the first only.
// R20: Wake-up is level input change, bus wake-up, or chip select rise. Code takes the chip select rise as wake-up in Stop only.
// R21: Sleep holds reset low until wake-up and regulated supply good.
// R22: Normal keeps regulator on, bus active, watchdog running if configured.
// R23: Mode bits: 00 Sleep, 01 Stop, 10 Normal plus clear, 11 Normal.
// R24: Bit 7 zero means status bits carry live real-time state.
// R25: Closed window is first half of period, open window second half.
module smw_mode_ctrl
   import smw_pkg::*;
#(
   parameter int WD_RES_PERIOD_CYC = smw_pkg::WD_DEFAULT_CYC,
   parameter int RESET_CYC = smw_pkg::RESET_STAY_CYC,
   parameter int VDD_LOW_LIMIT_CYC = smw_pkg::VDD_LOW_CYC,
   parameter int NREQ_LIMIT_CYC = smw_pkg::NREQ_CYC
) (
   // Clock and reset
   input wire logic clk,
   input wire logic rst_n,
   // Host command interface from the SPI shifter
   input wire smw_pkg::smw_cmd_type cmdData,
   input wire logic cmdValid,
   input wire logic statusRead,
   output logic [7:0] statusByte,
   // Pins
   input wire logic csPin_n,
   input wire logic levelInputOne,
   input wire logic levelInputTwo,
   input wire logic linBusWake,
   input wire logic linBusDominant,
   input wire logic txdPin,
   input wire logic wdPinGrounded,
   input wire logic wdResistorFitted,
   input wire smw_pkg::smw_cond_type cond,
   // Outputs
   output logic intPin_n,
   output logic rstPin_n,
   output logic rxdPin,
   output logic linDriveDominant,
   output logic [2:0] highSideSwitch,
   output logic regulatorOn,
   output logic [2:0] modeState
);
   import smw_pkg::*;

   logic rstMeta_n, rstSync_n;
   logic [SYNC_W-1:0] rawIn, syncIn;
   smw_state_type state, next_state;
   logic csSeen_n, levelOneSeen, levelTwoSeen, wakeEvent, lowPowerArmed, lowPowerState;
   logic [1:0] armedMode;
   logic wdFail, wdClear, timerLoad, timerExpired, timerPrimed, intPending;
   logic [CNT_W-1:0] wdPeriod, timerLoadValue, timerCount;
   logic [6:0] intSource, liveStatus, faultEvents, faultPrev;
   logic sLevelOne, sLevelTwo, sCs_n, sLinWake, sLinDom, sTxd;
   logic sVddGood, sRegTemp, sSwTemp, sOverVolt, sUnderVolt, sWdGround, sWdRes;

   // Reset release through two flops
   always_ff @(posedge clk or negedge rst_n) begin
      if (!rst_n) begin
         rstMeta_n <= 1'b0;
         rstSync_n <= 1'b0;
      end else begin
         rstMeta_n <= 1'b1;
         rstSync_n <= rstMeta_n;
      end
   end

   assign rawIn = {levelInputOne, levelInputTwo, csPin_n, linBusWake, linBusDominant, txdPin,
                   cond.vddGood, cond.regTempWarn, cond.switchOverTemp, cond.supplyOverVolt,
                   cond.supplyUnderVolt, wdPinGrounded, wdResistorFitted};

   smw_sync #(
      .W(SYNC_W)
   ) u_sync (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .d(rawIn),
      .q(syncIn)
   );

   assign {sLevelOne, sLevelTwo, sCs_n, sLinWake, sLinDom, sTxd, sVddGood, sRegTemp, sSwTemp,
           sOverVolt, sUnderVolt, sWdGround, sWdRes} = syncIn;

   assign lowPowerState = (state == SM_STOP) || (state == SM_SLEEP);

   // Wake-up source tracking
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         csSeen_n <= 1'b1;
         levelOneSeen <= 1'b0;
         levelTwoSeen <= 1'b0;
      end else begin
         csSeen_n <= sCs_n;
         levelOneSeen <= sLevelOne;
         levelTwoSeen <= sLevelTwo;
      end
   end

   assign wakeEvent = lowPowerState && ((sLevelOne != levelOneSeen) // R20
                      || (sLevelTwo != levelTwoSeen) || sLinWake
                      || (sCs_n && !csSeen_n && state == SM_STOP));

   // Two-command low-power entry
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         lowPowerArmed <= 1'b0;
         armedMode <= MODE_NORMAL;
      end else if (cmdValid) begin
         if (cmdData.linSlew == LOW_POWER_SEL && cmdData.switchEnable == SWITCHES_OFF
             && !cmdData.modeCtrl[1]) begin
            lowPowerArmed <= !(lowPowerArmed && armedMode == cmdData.modeCtrl); // R19
            armedMode <= cmdData.modeCtrl;
         end else begin
            lowPowerArmed <= 1'b0; // R19
         end
      end else if (state != SM_NORMAL && state != SM_NORMAL_REQ) begin
         lowPowerArmed <= 1'b0;
      end
   end

   // Watchdog clear decode, period selection
   assign wdClear = cmdValid && cmdData.modeCtrl == MODE_NORMAL_CLR; // R6 R23
   assign wdPeriod = sWdRes ? CNT_W'(WD_RES_PERIOD_CYC) // R10
                     : CNT_W'(WD_DEFAULT_CYC); // R9

   always_comb begin
      wdFail = 1'b0;
      if (!sWdGround) begin // R9
         if (state == SM_NORMAL_REQ) begin
            wdFail = timerExpired; // R8 R17
         end else if (state == SM_NORMAL) begin
            wdFail = timerExpired || (wdClear && timerCount > (wdPeriod >> 1)); // R7 R25
         end
      end
   end

   // Mode state machine
   always_comb begin
      next_state = state;
      case (state)
         SM_POWERUP: begin
            if (sVddGood) begin
               next_state = SM_RESET; // R15
            end else if (timerExpired && timerPrimed) begin
               next_state = SM_SLEEP; // R15
            end
         end
         SM_RESET: begin
            if (timerExpired) begin
               next_state = SM_NORMAL_REQ; // R16
            end
         end
         SM_NORMAL_REQ: begin
            if (wdFail || sUnderVolt) begin
               next_state = SM_RESET; // R17
            end else if (cmdValid && cmdData.modeCtrl[1]) begin
               next_state = SM_NORMAL; // R23
            end else if (cmdValid && lowPowerArmed && armedMode == cmdData.modeCtrl) begin
               next_state = (cmdData.modeCtrl == MODE_STOP) ? SM_STOP : SM_SLEEP;
            end
         end
         SM_NORMAL: begin
            if (wdFail || sUnderVolt) begin
               next_state = SM_RESET; // R7 R18
            end else if (cmdValid && lowPowerArmed && armedMode == cmdData.modeCtrl) begin
               next_state = (cmdData.modeCtrl == MODE_STOP) ? SM_STOP : SM_SLEEP; // R19
            end
         end
         SM_STOP: begin
            if (sUnderVolt) begin
               next_state = SM_RESET;
            end else if (wakeEvent) begin
               next_state = SM_NORMAL_REQ;
            end
         end
         SM_SLEEP: begin
            if (wakeEvent) begin
               next_state = SM_RESET; // R21
            end
         end
         default: begin
            next_state = SM_POWERUP;
         end
      endcase
   end

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         state <= SM_POWERUP;
         timerPrimed <= 1'b0;
      end else begin
         state <= next_state;
         timerPrimed <= 1'b1;
      end
   end

   // Shared timer: power-up wait, reset stay, first-clear timeout, watchdog period
   always_comb begin
      timerLoad = 1'b0;
      timerLoadValue = CNT_W'(RESET_CYC);
      if (!timerPrimed) begin
         timerLoad = 1'b1;
         timerLoadValue = CNT_W'(VDD_LOW_LIMIT_CYC); // R15
      end else if (next_state != state) begin
         timerLoad = 1'b1;
         case (next_state)
            SM_RESET: timerLoadValue = CNT_W'(RESET_CYC);
            SM_NORMAL_REQ: timerLoadValue = CNT_W'(NREQ_LIMIT_CYC);
            SM_NORMAL: timerLoadValue = wdPeriod;
            default: timerLoadValue = CNT_W'(VDD_LOW_LIMIT_CYC);
         endcase
      end else if (state == SM_NORMAL && wdClear) begin
         timerLoad = 1'b1; // R6
         timerLoadValue = wdPeriod;
      end
   end

   smw_timer #(
      .W(CNT_W)
   ) u_timer (
      .clk(clk),
      .rstSync_n(rstSync_n),
      .load(timerLoad),
      .loadValue(timerLoadValue),
      .run(1'b1),
      .count(timerCount),
      .expired(timerExpired)
   );

   // Live status and fault events
   assign liveStatus = {sLinWake, sOverVolt, sUnderVolt, sRegTemp && !lowPowerState, // R11 R12
                        sSwTemp && !lowPowerState, sLevelTwo, sLevelOne}; // R14

   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         faultPrev <= '0;
      end else begin
         faultPrev <= liveStatus;
      end
   end

   assign faultEvents = {1'b0, liveStatus[5:2] & ~faultPrev[5:2], 2'b00}; // R1

   // Interrupt source latch; a new event wins over the read clear
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         intSource <= '0;
         intPending <= 1'b0;
      end else if (faultEvents != '0 || (state == SM_STOP && wakeEvent)) begin
         intSource <= (statusRead ? 7'h00 : intSource) | faultEvents // R2
                      | {wakeEvent && sLinWake, 4'h0, wakeEvent && sLevelTwo,
                         wakeEvent && sLevelOne};
         intPending <= 1'b1;
      end else if (statusRead) begin
         intSource <= '0;
         intPending <= 1'b0;
      end
   end

   // Status byte: bit 7 selects latched source or live flags
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         statusByte <= 8'h00;
      end else begin
         statusByte <= intPending ? {1'b1, intSource} : {1'b0, liveStatus}; // R2 R24
      end
   end

   // Pin outputs
   always_ff @(posedge clk or negedge rstSync_n) begin
      if (!rstSync_n) begin
         intPin_n <= 1'b1;
         rstPin_n <= 1'b0;
         rxdPin <= 1'b1;
         linDriveDominant <= 1'b0;
         highSideSwitch <= SWITCHES_OFF;
         regulatorOn <= 1'b0;
         modeState <= 3'h0;
      end else begin
         intPin_n <= !(faultEvents != '0 || (state == SM_STOP && wakeEvent)); // R1 R3
         rstPin_n <= (state == SM_NORMAL_REQ || state == SM_NORMAL || state == SM_STOP)
                     && !wdFail && !sUnderVolt && sVddGood; // R7 R17 R18 R21
         rxdPin <= !sLinDom; // R4
         linDriveDominant <= !sTxd && (state == SM_NORMAL_REQ || state == SM_NORMAL); // R5 R22
         if (sSwTemp && !lowPowerState) begin
            highSideSwitch <= SWITCHES_OFF; // R13
         end else if (cmdValid && (state == SM_NORMAL || state == SM_NORMAL_REQ)) begin
            highSideSwitch <= cmdData.switchEnable;
         end else if (state != SM_NORMAL && state != SM_NORMAL_REQ) begin
            highSideSwitch <= SWITCHES_OFF;
         end
         regulatorOn <= (state != SM_SLEEP && state != SM_POWERUP); // R22
         modeState <= 3'(state);
      end
   end

   a_reset_on_fail: assert property (@(posedge clk) disable iff (!rstSync_n) // R7
      wdFail |=> !rstPin_n) else $error("reset output not low after watchdog fail");
   a_int_on_fault: assert property (@(posedge clk) disable iff (!rstSync_n) // R1
      (faultEvents != '0) |=> !intPin_n) else $error("no interrupt pulse on fault");
   a_stop_wake_int: assert property (@(posedge clk) disable iff (!rstSync_n) // R3
      (state == SM_STOP && wakeEvent) |=> !intPin_n) else $error("no stop wake interrupt");
   a_rxd_follows: assert property (@(posedge clk) disable iff (!rstSync_n) // R4
      ##1 rxdPin == !$past(sLinDom)) else $error("receive output wrong");
   a_switch_off_hot: assert property (@(posedge clk) disable iff (!rstSync_n) // R13
      (sSwTemp && !lowPowerState) |=> highSideSwitch == SWITCHES_OFF)
      else $error("switches on while hot");
   a_sleep_rst_low: assert property (@(posedge clk) disable iff (!rstSync_n) // R21
      (state == SM_SLEEP) |=> !rstPin_n) else $error("reset high in sleep");
   a_reset_to_req: assert property (@(posedge clk) disable iff (!rstSync_n) // R16
      (state == SM_RESET && timerExpired) |=> state == SM_NORMAL_REQ)
      else $error("reset stay did not end in normal request");
   a_low_warn_off: assert property (@(posedge clk) disable iff (!rstSync_n) // R12
      lowPowerState |-> !liveStatus[3] && !liveStatus[2]) else $error("thermal detect in low power");
   a_status_top: assert property (@(posedge clk) disable iff (!rstSync_n) // R2
      intPending |=> statusByte[7]) else $error("status bit 7 not set after interrupt");
endmodule

// ===== dv/smw_host_model.sv
// Host microcontroller model: command bytes, status reads, transmit and chip select
`timescale 1ns/1ps
module smw_host_model (
   // Clock
   input wire logic clk,
   // Status from the device
   input wire logic [7:0] statusByte,
   // Host lines
   output smw_pkg::smw_cmd_type cmdData,
   output logic cmdValid,
   output logic statusRead,
   output logic csPin_n,
   output logic txdPin
);
   import smw_pkg::*;

   initial begin
      cmdData = '0;
      cmdValid = 1'b0;
      statusRead = 1'b0;
      csPin_n = 1'b1;
      txdPin = 1'b1;
   end

   // One whole byte; data no longer holds once the strobe drops
   task automatic sendCmd(input smw_cmd_type c);
      @(posedge clk);
      cmdData <= c;
      cmdValid <= 1'b1;
      @(posedge clk);
      cmdValid <= 1'b0;
      cmdData <= ~c;
   endtask

   // Low-power request goes out twice in a row
   task automatic lowPower(input logic [1:0] m);
      repeat (2) sendCmd(smw_cmd_type'({2'h3, 1'b0, SWITCHES_OFF, m}));
   endtask

   // Caller picks the timing; the testbench sends it in Normal Request, the closed window and the open window
   task automatic wdClear(input logic [2:0] sw);
      sendCmd(smw_cmd_type'({2'h0, 1'b0, sw, MODE_NORMAL_CLR}));
   endtask

   task automatic normal(input logic [2:0] sw);
      sendCmd(smw_cmd_type'({2'h0, 1'b0, sw, MODE_NORMAL}));
   endtask

   // Read is reported at the edge; the byte is taken once that edge has settled
   task automatic readStatus(output logic [7:0] v);
      @(posedge clk);
      statusRead <= 1'b1;
      #1;
      v = statusByte;
      @(posedge clk);
      statusRead <= 1'b0;
   endtask

   task automatic setTxd(input logic b);
      @(posedge clk);
      txdPin <= b;
   endtask

   task automatic csRise();
      @(posedge clk);
      csPin_n <= 1'b0;
      repeat (3) @(posedge clk);
      csPin_n <= 1'b1;
   endtask
endmodule

// ===== dv/smw_testbench.sv
// Self-checking testbench for the mode sequencer and window watchdog
`timescale 1ns/1ps
module testbench;
   import smw_pkg::*;
   localparam int RC = 20;
   localparam int VL = 50;
   localparam int NR = 200;
   localparam int WP = 200;
   logic clk = 1'b0;
   logic rst_n = 1'b0;
   smw_cmd_type cmdData;
   logic cmdValid, statusRead, csPin_n, txdPin;
   logic [7:0] statusByte, st;
   logic levelInputOne, levelInputTwo, linBusWake, linBusDominant, wdPinGrounded;
   logic wdResistorFitted;
   smw_cond_type cond;
   logic intPin_n, rstPin_n, rxdPin, linDriveDominant, regulatorOn;
   logic [2:0] highSideSwitch, modeState;
   int mismatches = 0;
   int n_tests = 0;
   int k;
   int ci[3] = '{3, 2, 1};
   logic [7:0] src[3] = '{8'h08, 8'h04, 8'h20};

   always #20 clk = ~clk;

   smw_mode_ctrl #(.WD_RES_PERIOD_CYC(WP), .RESET_CYC(RC), .VDD_LOW_LIMIT_CYC(VL),
      .NREQ_LIMIT_CYC(NR)) uut (.clk(clk), .rst_n(rst_n), .cmdData(cmdData),
      .cmdValid(cmdValid), .statusRead(statusRead), .statusByte(statusByte),
      .csPin_n(csPin_n), .levelInputOne(levelInputOne), .levelInputTwo(levelInputTwo),
      .linBusWake(linBusWake), .linBusDominant(linBusDominant), .txdPin(txdPin),
      .wdPinGrounded(wdPinGrounded), .wdResistorFitted(wdResistorFitted), .cond(cond),
      .intPin_n(intPin_n), .rstPin_n(rstPin_n), .rxdPin(rxdPin),
      .linDriveDominant(linDriveDominant), .highSideSwitch(highSideSwitch),
      .regulatorOn(regulatorOn), .modeState(modeState));

   smw_host_model host (.clk(clk), .statusByte(statusByte), .cmdData(cmdData),
      .cmdValid(cmdValid), .statusRead(statusRead), .csPin_n(csPin_n), .txdPin(txdPin));

   task automatic stop_test();
      $display("Comparisons %0d mismatches %0d", n_tests, mismatches);
      if (mismatches == 0 && n_tests > 0) begin
         $display("ALL TESTS PASSED");
      end else begin
         $display("TESTS FAILED");
      end
      $finish;
   endtask

   task automatic check(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_tests++;
      if (got !== exp) begin
         mismatches++;
         $display("Error %s expected %h seen %h", name, exp, got);
      end
   endtask

   task automatic tick(input int n);
      repeat (n) @(posedge clk);
      #1;
   endtask

   // Bounded wait for a mode; a miss ends the run
   task automatic waitMode(input logic [2:0] m, input int lim);
      int i;
      for (i = 0; i < lim && modeState !== m; i++) begin
         tick(1);
      end
      check("modeState", {5'h0, m}, {5'h0, modeState});
      if (modeState !== m) stop_test();
   endtask

   // Interrupt pulse is one cycle wide, so every cycle is looked at
   task automatic waitInt(input int lim, input logic exp);
      int i;
      logic seen;
      seen = 1'b0;
      for (i = 0; i < lim && !seen; i++) begin
         tick(1);
         if (intPin_n === 1'b0) seen = 1'b1;
      end
      check("intPulse", {7'h0, exp}, {7'h0, seen});
   endtask

   task automatic doReset(input logic vdd);
      @(posedge clk);
      rst_n <= 1'b0;
      cond <= smw_cond_type'({vdd, 4'h0});
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      tick(3);
   endtask

   initial begin
      repeat (30000) @(posedge clk);
      mismatches++;
      stop_test();
   end

   initial begin
      {levelInputOne, levelInputTwo, linBusWake, linBusDominant} = 4'h0;
      {wdPinGrounded, wdResistorFitted} = 2'h3;
      cond = '0;
      // Watchdog disabled by grounded pin
      doReset(1'b1);
      waitMode(3'h1, 10);
      waitMode(3'h2, RC + 10);
      check("rstHigh", 8'h1, {7'h0, rstPin_n});
      host.setTxd(1'b0);
      tick(5);
      check("drive", 8'h1, {7'h0, linDriveDominant});
      host.setTxd(1'b1);
      tick(5);
      check("drive", 8'h0, {7'h0, linDriveDominant});
      @(posedge clk) linBusDominant <= 1'b1;
      tick(5);
      check("rxd", 8'h0, {7'h0, rxdPin});
      @(posedge clk) linBusDominant <= 1'b0;
      tick(5);
      check("rxd", 8'h1, {7'h0, rxdPin});
      tick(NR + 50);
      check("noTimeout", 8'h2, {5'h0, modeState});
      host.normal(3'h7);
      waitMode(3'h3, 10);
      tick(3);
      check("switches", 8'h7, {5'h0, highSideSwitch});
      check("regOn", 8'h1, {7'h0, regulatorOn});
      for (k = 0; k < 3; k++) begin
         @(posedge clk) cond[ci[k]] <= 1'b1;
         waitInt(10, 1'b1);
         tick(2);
         if (k == 1) check("switches", 8'h0, {5'h0, highSideSwitch});
         host.readStatus(st);
         check("srcByte", 8'h80 | src[k], st);
         tick(2);
         check("liveByte", src[k], statusByte);
         @(posedge clk) cond[ci[k]] <= 1'b0;
         tick(5);
         check("clearByte", 8'h00, statusByte);
         host.normal(3'h7);
      end
      tick(WP + 50);
      check("stayNormal", 8'h3, {5'h0, modeState});
      host.sendCmd(smw_cmd_type'({2'h3, 1'b0, SWITCHES_OFF, MODE_SLEEP}));
      host.normal(3'h0);
      tick(3);
      check("singleSleep", 8'h3, {5'h0, modeState});
      for (k = 0; k < 4; k++) begin
         host.lowPower(MODE_STOP);
         waitMode(3'h4, 10);
         if (k == 0) begin
            @(posedge clk) cond[3:2] <= 2'h3;
            waitInt(15, 1'b0);
            @(posedge clk) cond[3:2] <= 2'h0;
            tick(5);
         end
         @(posedge clk);
         case (k)
            0: levelInputOne <= ~levelInputOne;
            1: levelInputTwo <= ~levelInputTwo;
            2: linBusWake <= 1'b1;
            default: host.csRise();
         endcase
         if (k < 3) waitInt(20, 1'b1);
         waitMode(3'h2, 20);
         @(posedge clk) linBusWake <= 1'b0;
         host.normal(3'h0);
         waitMode(3'h3, 10);
      end
      host.lowPower(MODE_SLEEP);
      waitMode(3'h5, 10);
      tick(2);
      check("sleepRst", 8'h0, {7'h0, rstPin_n});
      @(posedge clk) linBusWake <= 1'b1;
      waitMode(3'h1, 20);
      @(posedge clk) linBusWake <= 1'b0;
      waitMode(3'h2, RC + 10);
      check("wakeRst", 8'h1, {7'h0, rstPin_n});
      host.normal(3'h0);
      waitMode(3'h3, 10);
      @(posedge clk) cond.supplyUnderVolt <= 1'b1;
      waitInt(10, 1'b1);
      waitMode(3'h1, 10);
      check("uvRst", 8'h0, {7'h0, rstPin_n});
      @(posedge clk) cond.supplyUnderVolt <= 1'b0;
      // Watchdog on, resistor period
      @(posedge clk) wdPinGrounded <= 1'b0;
      doReset(1'b1);
      waitMode(3'h2, RC + 10);
      tick(NR - 30);
      check("nreqWait", 8'h2, {5'h0, modeState});
      waitMode(3'h1, 50);
      waitMode(3'h2, RC + 10);
      tick(NR - 30);
      host.wdClear(3'h0);
      waitMode(3'h3, 10);
      tick(10);
      host.wdClear(3'h0);
      waitMode(3'h1, 10);
      check("wdRst", 8'h0, {7'h0, rstPin_n});
      waitMode(3'h2, RC + 10);
      host.wdClear(3'h0);
      waitMode(3'h3, 10);
      tick(WP / 2 + 20);
      host.wdClear(3'h0);
      tick(5);
      check("openClear", 8'h3, {5'h0, modeState});
      tick(WP - 30);
      check("beforeEnd", 8'h3, {5'h0, modeState});
      waitMode(3'h1, 50);
      // Default period when no resistor is fitted outlasts the resistor period
      @(posedge clk) wdResistorFitted <= 1'b0;
      waitMode(3'h2, RC + 10);
      host.normal(3'h0);
      waitMode(3'h3, 10);
      tick(WP + 50);
      check("defaultPeriod", 8'h3, {5'h0, modeState});
      // Supply never comes up
      doReset(1'b0);
      waitMode(3'h5, VL + 20);
      stop_test();
   end
endmodule
